// file: hdl/mem_map_pkg.sv
// Constants, region codes and helpers shared by the address map decoder.
package mem_map_pkg;

  // Address width of the single unified program and data space.
  localparam int ADDR_W = 16;

  // Register offsets on the software port.
  localparam logic [7:0] REG_MEM_SIZE = 8'h00;
  localparam logic [7:0] REG_EXP_SIZE = 8'h01;
  localparam logic [7:0] REG_BANK = 8'h02;
  localparam logic [7:0] REG_CONFIG = 8'h03;
  localparam logic [7:0] REG_STATUS = 8'h04;

  // Values after reset.
  localparam logic [7:0] MEM_SIZE_RST = 8'hcf;
  localparam logic [7:0] EXP_SIZE_RST = 8'h0c;
  localparam logic [2:0] BANK_RST = 3'h0;
  localparam logic [4:0] CONFIG_RST = 5'h00;

  // Memory size select codes.
  localparam logic [7:0] MS_16K = 8'h04;
  localparam logic [7:0] MS_24K = 8'hc6;
  localparam logic [7:0] MS_32K = 8'hc8;
  localparam logic [7:0] MS_48K = 8'hcc;
  localparam logic [7:0] MS_60K = 8'hcf;

  // Expansion RAM size select codes.
  localparam logic [7:0] XS_NONE = 8'h0c;
  localparam logic [7:0] XS_1K = 8'h0a;
  localparam logic [7:0] XS_2K = 8'h0b;
  localparam logic [7:0] XS_4K = 8'h04;
  localparam logic [7:0] XS_6K = 8'h00;

  // Flash upper limits in the flat layout.
  localparam logic [15:0] ROM_TOP_16K = 16'h3fff;
  localparam logic [15:0] ROM_TOP_24K = 16'h5fff;
  localparam logic [15:0] ROM_TOP_32K = 16'h7fff;
  localparam logic [15:0] ROM_TOP_48K = 16'hbfff;
  localparam logic [15:0] ROM_TOP_60K = 16'hefff;

  // Banked layout: common area and the bank window.
  localparam logic [15:0] COMMON_TOP = 16'h7fff;
  localparam logic [15:0] BANK_BASE = 16'h8000;
  localparam logic [15:0] BANK_TOP = 16'hbfff;
  localparam logic [2:0] BANKS_FOUR = 3'h4;
  localparam logic [2:0] BANKS_SIX = 3'h6;

  // Expansion RAM bases; all end at the same top.
  localparam logic [15:0] EXP_TOP = 16'hf7ff;
  localparam logic [15:0] EXP_BASE_1K = 16'hf400;
  localparam logic [15:0] EXP_BASE_2K = 16'hf000;
  localparam logic [15:0] EXP_BASE_4K = 16'he800;
  localparam logic [15:0] EXP_BASE_6K = 16'he000;

  // High-speed RAM, general registers and peripheral registers.
  localparam logic [15:0] HS_BASE_1K = 16'hfb00;
  localparam logic [15:0] HS_BASE_768 = 16'hfc00;
  localparam logic [15:0] HS_TOP = 16'hfedf;
  localparam logic [15:0] GPR_BASE = 16'hfee0;
  localparam logic [15:0] GPR_TOP = 16'hfeff;
  localparam logic [15:0] PERI_BASE = 16'hff00;
  localparam logic [15:0] PERI_TOP = 16'hffff;

  // Fixed areas at the bottom of flash.
  localparam logic [15:0] VEC_BASE = 16'h0000;
  localparam logic [15:0] VEC_TOP = 16'h003f;
  localparam logic [15:0] CALL_BASE = 16'h0040;
  localparam logic [15:0] CALL_TOP = 16'h007f;
  localparam logic [15:0] OPT_BASE = 16'h0080;
  localparam logic [15:0] OPT_TOP = 16'h0084;
  localparam logic [15:0] DBG_BASE = 16'h0085;
  localparam logic [15:0] DBG_TOP = 16'h008e;
  localparam logic [15:0] SWAP_OFS = 16'h1000;
  localparam logic [15:0] BOOT0_BASE = 16'h0000;
  localparam logic [15:0] BOOT0_TOP = 16'h0fff;

  // Configuration register bit positions.
  localparam int CFG_SWAP_BIT = 0;
  localparam int CFG_DEBUG_BIT = 1;
  localparam int CFG_PROT_BIT = 2;
  localparam int CFG_BANKED_BIT = 3;
  localparam int CFG_SIX_BIT = 4;

  // Status register bit positions.
  localparam int STAT_BLOCK_BIT = 7;
  localparam int STAT_BANK_ERR_BIT = 6;

  // Region codes, also the bit index in the one-hot select.
  typedef enum logic [2:0] {
    RG_NONE = 3'b000,
    RG_FLASH = 3'b001,
    RG_BANK = 3'b010,
    RG_HSRAM = 3'b011,
    RG_GPR = 3'b100,
    RG_EXPRAM = 3'b101,
    RG_PERI = 3'b110
  } region_e;

  // True when the address lies inside an inclusive range.
  function automatic logic in_range(input logic [15:0] a,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

endpackage : mem_map_pkg

// file: hdl/map_limits_if.sv
// Decoded region limits passed from the size decoder to the top.
`timescale 1ns/1ps
interface map_limits_if;
  logic rom_en;
  logic [15:0] rom_top;
  logic banked;
  logic [15:0] hs_base;
  logic exp_en;
  logic [15:0] exp_base;

  modport src (output rom_en, rom_top, banked, hs_base, exp_en, exp_base);
  modport dst (input rom_en, rom_top, banked, hs_base, exp_en, exp_base);
endinterface : map_limits_if

// file: hdl/size_decode.sv
// Turns the two size select values into region limits.
`timescale 1ns/1ps
module size_decode
  import mem_map_pkg::*;
(
  input wire logic [7:0] mem_size_i,   // Memory size select value.
  input wire logic [7:0] exp_size_i,   // Expansion RAM size select value.
  input wire logic banked_cfg_i,       // Banked flash fitted.
  map_limits_if.src lim                // Decoded limits.
);

  // Flash top and high-speed RAM base from the memory size select.
  always_comb
  begin
    lim.rom_en = 1'b1;
    lim.rom_top = ROM_TOP_60K;
    lim.hs_base = HS_BASE_1K;
    lim.banked = 1'b0;
    case (mem_size_i)
      MS_16K:
      begin
        lim.rom_top = ROM_TOP_16K;
        lim.hs_base = HS_BASE_768;
      end
      MS_24K: lim.rom_top = ROM_TOP_24K;
      MS_32K: lim.rom_top = ROM_TOP_32K;
      MS_48K:
      begin
        lim.rom_top = ROM_TOP_48K;
        lim.banked = banked_cfg_i;
      end
      MS_60K: lim.rom_top = ROM_TOP_60K;
      default: lim.rom_en = 1'b0;
    endcase
  end

  // Expansion RAM base from the expansion RAM size select.
  always_comb
  begin
    lim.exp_en = 1'b1;
    lim.exp_base = EXP_BASE_1K;
    case (exp_size_i)
      XS_1K: lim.exp_base = EXP_BASE_1K;
      XS_2K: lim.exp_base = EXP_BASE_2K;
      XS_4K: lim.exp_base = EXP_BASE_4K;
      XS_6K: lim.exp_base = EXP_BASE_6K;
      default: lim.exp_en = 1'b0;
    endcase
  end

endmodule : size_decode

// file: hdl/bank_window.sv
// Checks the selected flash bank against the number fitted.
`timescale 1ns/1ps
module bank_window
  import mem_map_pkg::*;
(
  input wire logic [2:0] bank_i,       // Selected bank number.
  input wire logic six_banks_i,        // Six banks fitted, else four.
  output logic bank_ok_o               // Bank exists.
);

  logic [2:0] count;

  // Only banks below the fitted count are reachable.
  always_comb
  begin
    count = six_banks_i ? BANKS_SIX : BANKS_FOUR;
    bank_ok_o = bank_i < count;
  end

endmodule : bank_window

// file: hdl/memory_map_size_decoder.sv
// Address map decoder with size, bank and configuration registers.
`timescale 1ns/1ps
module memory_map_size_decoder
  import mem_map_pkg::*;
(
  input wire logic ref_clk_i,                  // Clock, 250 MHz.
  input wire logic arst_n_i,                   // Async reset, low.
  input wire logic [7:0] reg_addr_i,           // Register offset.
  input wire logic [7:0] reg_wdata_i,          // Register write data.
  input wire logic reg_wr_i,                   // Register write strobe.
  input wire logic reg_rd_i,                   // Register read strobe.
  output logic [7:0] reg_rdata_o,              // Read data, next cycle.
  input wire logic access_i,                   // CPU access this cycle.
  input wire logic fetch_i,                    // Access is a fetch.
  input wire logic write_i,                    // Access is a write.
  input wire logic [15:0] data_addr_i,         // Data address.
  input wire logic [15:0] instruction_pointer_i, // Fetch address.
  output region_e region_o,                    // Decoded region code.
  output logic [6:0] region_sel_o,             // One-hot region select.
  output logic [2:0] flash_bank_o,             // Bank in the window.
  output logic vector_area_o,                  // Vector table hit.
  output logic call_table_o,                   // Call table hit.
  output logic option_byte_o,                  // Option byte hit.
  output logic debug_id_o,                     // Debug ID hit.
  output logic write_block_o                   // Write refused.
);

  // Software registers.
  logic [7:0] memory_size_select;
  logic [7:0] expansion_ram_size_select;
  logic [2:0] bank_select;
  logic [4:0] config_bits;
  logic block_seen;
  logic bank_err_seen;
  region_e last_region;

  // Decode results.
  logic [15:0] addr;
  logic bank_ok;
  logic in_flash;
  logic in_bank;
  logic swap_en;
  logic hit_blocked;
  logic bank_miss;
  region_e next_region;
  logic [7:0] next_rdata;

  map_limits_if lim ();

  // Size select values become region limits.
  size_decode u_size (
    .mem_size_i (memory_size_select),
    .exp_size_i (expansion_ram_size_select),
    .banked_cfg_i (config_bits[CFG_BANKED_BIT]),
    .lim (lim.src)
  );

  // Bank register checked against the number of banks fitted.
  bank_window u_bank (
    .bank_i (bank_select),
    .six_banks_i (config_bits[CFG_SIX_BIT]),
    .bank_ok_o (bank_ok)
  );

  // Fetches take the instruction pointer, data accesses the address.
  assign addr = fetch_i ? instruction_pointer_i : data_addr_i;

  assign swap_en = config_bits[CFG_SWAP_BIT];

  // Flash hit tests for the flat and the banked layout.
  always_comb
  begin
    if (lim.banked)
    begin
      in_flash = in_range(addr, 16'h0000, COMMON_TOP);
      in_bank = in_range(addr, BANK_BASE, BANK_TOP) && bank_ok;
    end
    else
    begin
      in_flash = lim.rom_en && in_range(addr, 16'h0000, lim.rom_top);
      in_bank = 1'b0;
    end
  end

  // One region per address; upper areas win over flash on overlap.
  always_comb
  begin
    next_region = RG_NONE;
    if (in_range(addr, PERI_BASE, PERI_TOP))
      next_region = RG_PERI;
    else if (in_range(addr, GPR_BASE, GPR_TOP))
      next_region = RG_GPR;
    else if (in_range(addr, lim.hs_base, HS_TOP))
      next_region = RG_HSRAM;
    else if (lim.exp_en && in_range(addr, lim.exp_base, EXP_TOP))
      next_region = RG_EXPRAM;
    else if (in_bank)
      next_region = RG_BANK;
    else if (in_flash)
      next_region = RG_FLASH;
  end

  // Region code and one-hot select follow the address directly.
  always_comb
  begin
    region_o = next_region;
    region_sel_o = 7'h00;
    if (next_region != RG_NONE)
      region_sel_o[next_region] = 1'b1;
  end

  // Bank number presented to the flash from the bank register.
  assign flash_bank_o = bank_select;

  // Fixed areas inside the bottom of flash.
  always_comb
  begin
    vector_area_o = in_flash && in_range(addr, VEC_BASE, VEC_TOP);
    call_table_o = in_flash && in_range(addr, CALL_BASE, CALL_TOP);
    option_byte_o = in_flash && (in_range(addr, OPT_BASE, OPT_TOP) ||
      (swap_en && in_range(addr, 16'(OPT_BASE + SWAP_OFS),
                           16'(OPT_TOP + SWAP_OFS))));
    debug_id_o = in_flash && config_bits[CFG_DEBUG_BIT] &&
      (in_range(addr, DBG_BASE, DBG_TOP) ||
       (swap_en && in_range(addr, 16'(DBG_BASE + SWAP_OFS),
                            16'(DBG_TOP + SWAP_OFS))));
  end

  // Writes into boot cluster 0 are refused while protection is set.
  always_comb
  begin
    hit_blocked = access_i && write_i && !fetch_i &&
      config_bits[CFG_PROT_BIT] && in_flash &&
      in_range(addr, BOOT0_BASE, BOOT0_TOP);
    write_block_o = hit_blocked;
  end

  // A window access with an unfitted bank selects nothing.
  assign bank_miss = access_i && lim.banked && !bank_ok &&
    in_range(addr, BANK_BASE, BANK_TOP);

  // Size select registers; both load fixed values at reset.
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      memory_size_select <= MEM_SIZE_RST;
      expansion_ram_size_select <= EXP_SIZE_RST;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == REG_MEM_SIZE)
        memory_size_select <= reg_wdata_i;
      if (reg_addr_i == REG_EXP_SIZE)
        expansion_ram_size_select <= reg_wdata_i;
    end
  end

  // Bank select and configuration registers.
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      bank_select <= BANK_RST;
      config_bits <= CONFIG_RST;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == REG_BANK)
        bank_select <= reg_wdata_i[2:0];
      if (reg_addr_i == REG_CONFIG)
        config_bits <= reg_wdata_i[4:0];
    end
  end

  // Sticky status flags; a new event wins over a write-one clear.
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      block_seen <= 1'b0;
      bank_err_seen <= 1'b0;
    end
    else
    begin
      if (hit_blocked)
        block_seen <= 1'b1;
      else if (reg_wr_i && reg_addr_i == REG_STATUS &&
               reg_wdata_i[STAT_BLOCK_BIT])
        block_seen <= 1'b0;
      if (bank_miss)
        bank_err_seen <= 1'b1;
      else if (reg_wr_i && reg_addr_i == REG_STATUS &&
               reg_wdata_i[STAT_BANK_ERR_BIT])
        bank_err_seen <= 1'b0;
    end
  end

  // Region of the most recent CPU access, for software to inspect.
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      last_region <= RG_NONE;
    else if (access_i)
      last_region <= next_region;
  end

  // Read multiplexer; unmapped offsets read as zero.
  always_comb
  begin
    next_rdata = 8'h00;
    case (reg_addr_i)
      REG_MEM_SIZE: next_rdata = memory_size_select;
      REG_EXP_SIZE: next_rdata = expansion_ram_size_select;
      REG_BANK: next_rdata = {5'h00, bank_select};
      REG_CONFIG: next_rdata = {3'h0, config_bits};
      REG_STATUS: next_rdata = {block_seen, bank_err_seen, 3'h0,
                                last_region};
      default: next_rdata = 8'h00;
    endcase
  end

  // Read data stands for one cycle after the read strobe, else zero.
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      reg_rdata_o <= 8'h00;
    else if (reg_rd_i)
      reg_rdata_o <= next_rdata;
    else
      reg_rdata_o <= 8'h00;
  end

endmodule : memory_map_size_decoder

// file: sim/map_checker.sv
// Port assertions for the address map decoder.
`timescale 1ns/1ps
module map_checker
  import mem_map_pkg::*;
(
  input wire logic ref_clk_i, // Clock.
  input wire logic arst_n_i, // Reset.
  input wire logic [7:0] reg_addr_i, // Offset.
  input wire logic [7:0] reg_wdata_i, // Data.
  input wire logic reg_wr_i, // Write.
  input wire logic reg_rd_i, // Read.
  input wire logic [7:0] reg_rdata_o, // Read data.
  input wire logic access_i, // Access.
  input wire logic fetch_i, // Fetch.
  input wire logic write_i, // Write.
  input wire logic [15:0] data_addr_i, // Data address.
  input wire logic [15:0] instruction_pointer_i, // Fetch address.
  input wire region_e region_o, // Region.
  input wire logic [6:0] region_sel_o, // Select.
  input wire logic [2:0] flash_bank_o, // Bank.
  input wire logic vector_area_o, // Vector.
  input wire logic call_table_o, // Call table.
  input wire logic option_byte_o, // Option.
  input wire logic debug_id_o, // Debug ID.
  input wire logic write_block_o // Blocked.
);
  // Decoded address, and the same with the swap copy folded down.
  logic [15:0] ea;
  logic [15:0] fold;
  assign ea = fetch_i ? instruction_pointer_i : data_addr_i;
  assign fold = ea & 16'hefff;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence bank_write;
    reg_wr_i && reg_addr_i == REG_BANK;
  endsequence
  sequence bank_shown;
    flash_bank_o == $past(reg_wdata_i[2:0]);
  endsequence
  a_bank_follows: assert property (bank_write |=> bank_shown)
    else $error("bank output does not follow write");
  a_read_pulse: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data outside its cycle");
  a_sel_code: assert property (region_sel_o ==
    (region_o == RG_NONE ? 7'h00 : 7'h01 << region_o))
    else $error("select does not match region");
  a_peri_area: assert property (ea >= 16'hff00 |-> region_o == RG_PERI)
    else $error("peripheral area missed");
  a_gpr_area: assert property (ea >= 16'hfee0 && ea <= 16'hfeff
    |-> region_o == RG_GPR) else $error("register area missed");
  a_hs_area: assert property (region_o == RG_HSRAM
    |-> ea >= 16'hfb00 && ea <= 16'hfedf) else $error("fast RAM range");
  a_window_area: assert property (region_o == RG_BANK
    |-> ea >= 16'h8000 && ea <= 16'hbfff) else $error("window range");
  a_vector_flag: assert property (vector_area_o
    |-> ea <= 16'h003f && region_o == RG_FLASH) else $error("vector flag");
  a_call_flag: assert property (call_table_o
    |-> ea >= 16'h0040 && ea <= 16'h007f) else $error("call flag");
  a_option_flag: assert property (option_byte_o
    |-> fold >= 16'h0080 && fold <= 16'h0084) else $error("option flag");
  a_debug_flag: assert property (debug_id_o
    |-> fold >= 16'h0085 && fold <= 16'h008e) else $error("debug flag");
  a_block_cause: assert property (write_block_o
    |-> access_i && write_i && !fetch_i && ea <= 16'h0fff)
    else $error("write refused without cause");
endmodule : map_checker

bind memory_map_size_decoder map_checker u_chk (.ref_clk_i(ref_clk_i),
  .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .access_i(access_i), .fetch_i(fetch_i), .write_i(write_i),
  .data_addr_i(data_addr_i), .instruction_pointer_i(instruction_pointer_i),
  .region_o(region_o), .region_sel_o(region_sel_o),
  .flash_bank_o(flash_bank_o), .vector_area_o(vector_area_o),
  .call_table_o(call_table_o), .option_byte_o(option_byte_o),
  .debug_id_o(debug_id_o), .write_block_o(write_block_o));

// file: sim/cpu_path_model.sv
// Behavioural CPU fetch and data access path facing the decoder.
`timescale 1ns/1ps
module cpu_path_model (
  input wire logic clk_i, // Clock.
  output logic access_o, // Access.
  output logic fetch_o, // Fetch.
  output logic write_o, // Data write.
  output logic [15:0] data_addr_o, // Data address.
  output logic [15:0] ip_o // Instruction pointer.
);
  // Idle at time zero.
  initial
  begin
    access_o = 1'b0;
    fetch_o = 1'b0;
    write_o = 1'b0;
    data_addr_o = 16'h0000;
    ip_o = 16'h0000;
  end
  // One access; the unused address carries the inverse as a decoy.
  task automatic issue(input logic f, w, input logic [15:0] a);
    @(posedge clk_i);
    access_o <= 1'b1;
    fetch_o <= f;
    write_o <= w && !f;
    ip_o <= f ? a : ~a;
    data_addr_o <= f ? ~a : a;
    #1;
  endtask : issue
  // Drop the access; both address buses flip so no old value lingers.
  task automatic idle;
    @(posedge clk_i);
    access_o <= 1'b0;
    write_o <= 1'b0;
    ip_o <= ~ip_o;
    data_addr_o <= ~data_addr_o;
  endtask : idle
endmodule : cpu_path_model

// file: sim/tb_top.sv
// Self-checking bench for the address map decoder.
`timescale 1ns/1ps
module tb_top;
  import mem_map_pkg::*;
  logic ref_clk, arst_n, reg_wr, reg_rd, acc, fch, wrt;
  logic vec, call_tab, opt, dbg, wblk;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
  logic [15:0] da, ip;
  logic [6:0] sel;
  logic [2:0] bank;
  region_e region;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;
  // Clock.
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  cpu_path_model u_cpu (.clk_i(ref_clk), .access_o(acc), .fetch_o(fch),
    .write_o(wrt), .data_addr_o(da), .ip_o(ip));
  memory_map_size_decoder dut (.ref_clk_i(ref_clk), .arst_n_i(arst_n),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .access_i(acc),
    .fetch_i(fch), .write_i(wrt), .data_addr_i(da),
    .instruction_pointer_i(ip), .region_o(region), .region_sel_o(sel),
    .flash_bank_o(bank), .vector_area_o(vec), .call_table_o(call_tab),
    .option_byte_o(opt), .debug_id_o(dbg), .write_block_o(wblk));
  // Verdict and end of run.
  task automatic report_and_stop;
    if (n_mismatch == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop
  // Compare and count.
  task automatic chk(input string what, input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Register bus write and read.
  task automatic wr(input logic [7:0] a, d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // One access and its region.
  task automatic probe(input logic f, w, input logic [15:0] a, region_e r);
    u_cpu.issue(f, w, a);
    chk("region", region, r);
  endtask : probe
  // Reset values, unmapped offset and the default map.
  task automatic t_reset;
    rd(REG_MEM_SIZE, v);
    chk("mem size", v, 8'hcf);
    rd(REG_EXP_SIZE, v);
    chk("exp size", v, 8'h0c);
    rd(8'h10, v);
    chk("unmapped", v, 8'h00);
    probe(1'b0, 1'b0, 16'hefff, RG_FLASH);
    probe(1'b0, 1'b0, 16'hf000, RG_NONE);
    probe(1'b0, 1'b0, 16'hfaff, RG_NONE);
    probe(1'b0, 1'b0, 16'hfb00, RG_HSRAM);
    probe(1'b0, 1'b0, 16'hfedf, RG_HSRAM);
    probe(1'b0, 1'b0, 16'hfee0, RG_GPR);
    probe(1'b0, 1'b0, 16'hfeff, RG_GPR);
    probe(1'b0, 1'b0, 16'hffff, RG_PERI);
    chk("select", sel, 16'h0040);
  endtask : t_reset
  // Every memory size code: flash limit and fast RAM size.
  task automatic t_sizes;
    logic [7:0] ms [5] = '{8'h04, 8'hc6, 8'hc8, 8'hcc, 8'hcf};
    logic [15:0] top [5] = '{16'h3fff, 16'h5fff, 16'h7fff, 16'hbfff,
      16'hefff};
    for (int i = 0; i < 5; i++)
    begin
      wr(REG_MEM_SIZE, ms[i]);
      probe(1'b1, 1'b0, top[i], RG_FLASH);
      probe(1'b0, 1'b0, top[i] + 16'h0001, RG_NONE);
      probe(1'b0, 1'b0, 16'hfb00, i == 0 ? RG_NONE : RG_HSRAM);
    end
    wr(REG_MEM_SIZE, 8'h04);
    probe(1'b0, 1'b0, 16'hfc00, RG_HSRAM);
  endtask : t_sizes
  // Every expansion size code, with a 16 KB flash below.
  task automatic t_exp;
    logic [7:0] xs [4] = '{8'h0a, 8'h0b, 8'h04, 8'h00};
    logic [15:0] base [4] = '{16'hf400, 16'hf000, 16'he800, 16'he000};
    for (int i = 0; i < 4; i++)
    begin
      wr(REG_EXP_SIZE, xs[i]);
      probe(1'b0, 1'b0, base[i], RG_EXPRAM);
      probe(1'b0, 1'b0, base[i] - 16'h0001, RG_NONE);
      probe(1'b1, 1'b0, 16'hf7ff, RG_EXPRAM);
    end
    wr(REG_EXP_SIZE, 8'h0c);
    probe(1'b0, 1'b0, 16'hf7ff, RG_NONE);
  endtask : t_exp
  // Banked flash: common area, window, unfitted banks.
  task automatic t_bank;
    wr(REG_MEM_SIZE, 8'hcc);
    wr(REG_CONFIG, 8'h18);
    wr(REG_BANK, 8'h05);
    probe(1'b0, 1'b0, 16'h7fff, RG_FLASH);
    probe(1'b1, 1'b0, 16'h8000, RG_BANK);
    chk("bank", bank, 16'h0005);
    probe(1'b0, 1'b0, 16'hbfff, RG_BANK);
    probe(1'b0, 1'b0, 16'hc000, RG_NONE);
    wr(REG_BANK, 8'h06);
    probe(1'b0, 1'b0, 16'h8000, RG_NONE);
    wr(REG_CONFIG, 8'h08);
    wr(REG_BANK, 8'h03);
    probe(1'b0, 1'b0, 16'h8000, RG_BANK);
    wr(REG_BANK, 8'h04);
    probe(1'b0, 1'b0, 16'h8000, RG_NONE);
    rd(REG_STATUS, v);
    chk("bank err", v[6], 16'h0001);
  endtask : t_bank
  // Fixed areas at the bottom of flash, with and without swap.
  task automatic t_fixed;
    wr(REG_MEM_SIZE, 8'hcf);
    wr(REG_CONFIG, 8'h02);
    probe(1'b0, 1'b0, 16'h003f, RG_FLASH);
    chk("vector", vec, 16'h0001);
    probe(1'b0, 1'b0, 16'h0040, RG_FLASH);
    chk("call", {vec, call_tab}, 16'h0001);
    probe(1'b0, 1'b0, 16'h0084, RG_FLASH);
    chk("option", {opt, dbg, call_tab}, 16'h0004);
    probe(1'b0, 1'b0, 16'h0085, RG_FLASH);
    chk("debug", {opt, dbg}, 16'h0001);
    probe(1'b0, 1'b0, 16'h008f, RG_FLASH);
    chk("debug end", dbg, 16'h0000);
    probe(1'b0, 1'b0, 16'h1080, RG_FLASH);
    chk("no mirror", opt, 16'h0000);
    wr(REG_CONFIG, 8'h03);
    probe(1'b0, 1'b0, 16'h1080, RG_FLASH);
    chk("mirror", opt, 16'h0001);
    probe(1'b0, 1'b0, 16'h108e, RG_FLASH);
    chk("id mirror", dbg, 16'h0001);
  endtask : t_fixed
  // Boot cluster writes refused only when protected.
  task automatic t_block;
    wr(REG_CONFIG, 8'h04);
    wr(REG_STATUS, 8'hc0);
    probe(1'b0, 1'b1, 16'h0fff, RG_FLASH);
    chk("block", wblk, 16'h0001);
    probe(1'b1, 1'b1, 16'h0fff, RG_FLASH);
    chk("fetch", wblk, 16'h0000);
    probe(1'b0, 1'b1, 16'h1000, RG_FLASH);
    chk("above", wblk, 16'h0000);
    u_cpu.idle;
    rd(REG_STATUS, v);
    chk("seen", v[7], 16'h0001);
    wr(REG_CONFIG, 8'h00);
    probe(1'b0, 1'b1, 16'h0000, RG_FLASH);
    chk("open", wblk, 16'h0000);
  endtask : t_block
  // Fetch follows the instruction pointer, data the data address.
  task automatic t_fetch;
    probe(1'b1, 1'b0, 16'h0081, RG_FLASH);
    chk("fetch option", opt, 16'h0001);
    probe(1'b0, 1'b0, 16'hff00, RG_PERI);
    u_cpu.idle;
  endtask : t_fetch
  // Cut a hang short.
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_mismatch++;
      report_and_stop;
    end
  end
  // Reset, then the scenarios.
  initial
  begin
    arst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_reset;
    t_sizes;
    t_exp;
    t_bank;
    t_fixed;
    t_block;
    t_fetch;
    report_and_stop;
  end
endmodule : tb_top
